// ---- common/ueb_pkg.sv ----
package ueb_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_DIV_LO = 8'h00; // reads zero, write ignored when access bit clear
    localparam logic [7:0] OFF_DIV_HI = 8'h04; // reads zero when access bit clear
    localparam logic [7:0] OFF_EFR = 8'h08;
    localparam logic [7:0] OFF_LCR = 8'h0c;
    localparam logic [7:0] OFF_RESUME_CHAR_ONE = 8'h10;
    localparam logic [7:0] OFF_RESUME_CHAR_TWO = 8'h14;
    localparam logic [7:0] OFF_MSR = 8'h18; // also pause_char_one
    localparam logic [7:0] OFF_SCR = 8'h1c; // also pause_char_two
    localparam logic [7:0] OFF_ABEN = 8'h20;
    localparam logic [7:0] OFF_SPEED = 8'h24;
    localparam logic [7:0] OFF_SCNT = 8'h28;
    localparam logic [7:0] OFF_SPNT = 8'h2c;
    localparam logic [7:0] OFF_ABRES = 8'h30;
    localparam logic [7:0] OFF_RFIX = 8'h34;
    localparam logic [7:0] OFF_ABDUR = 8'h38;
    localparam logic [7:0] OFF_GUARD = 8'h3c;
    localparam logic [7:0] OFF_ESCV = 8'h40;
    localparam logic [7:0] OFF_ESCEN = 8'h44;
    localparam logic [7:0] OFF_SLEEP = 8'h48;
    localparam logic [7:0] OFF_VFIFO = 8'h4c;
    localparam logic [7:0] OFF_RXTRIG = 8'h50;
    localparam logic [7:0] OFF_FLOWST = 8'h54; // block state
    // values after reset
    localparam logic [15:0] RST_DIV = 16'h0001;
    localparam logic [7:0] RST_SPNT = 8'hff;
    localparam logic [6:0] RST_ABDUR = 7'h0d;
    localparam logic [7:0] RST_ESCV = 8'hff;
    localparam logic [7:0] ENH_KEY = 8'hbf;
    // field positions
    localparam int LCR_DIVISOR_ACCESS_BIT = 7;
    localparam int EFR_ACTS = 7;
    localparam int EFR_ARTS = 6;
    localparam int RF_FIX = 0;
    localparam int RF_ABFIX = 1;
    localparam int RF_FSEL = 2;
    localparam int RF_RESTR = 3;
    localparam int GD_EN = 4;
    // oversampling base per speed value
    localparam logic [7:0] BASE_16 = 8'h0f;
    localparam logic [7:0] BASE_8 = 8'h07;
    localparam logic [7:0] BASE_4 = 8'h03;
    localparam logic [1:0] TRIG_PROG = 2'b11;
    // 13 MHz tick from 26 MHz tick
    localparam logic [2:0] TICK26_DIV = 3'h4;
    typedef enum logic [1:0] {UEB_AB_IDLE, UEB_AB_ARM, UEB_AB_RUN} ueb_ab_t;
endpackage : ueb_pkg

// ---- hdl/ueb_core.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - modem delta flags set on change, read clears
// - ring flag on low-to-high since read
// - scratch byte reads back, access bit clear
// - divisor writes need access bit; one=tick high
// - default mode tick is sixteen per bit
// - feature and flow chars mapped only at BFh
// - auto clear pauses tx, auto request tracks space
// - upper flow bits pick transmit characters
// - lower flow bits pick recognised characters
// - speed field picks 16, 8, 4 or count
// - speed three counts zero to sample count
// - speed three samples at programmed point
// - rate fix gates tx/rx on chosen tick
// - autobaud rate fix gates autobaud on tick
// - restrict adds condition leaving autobaud start
// - guard idle after stop, count times step
// - tx escapes flow chars, sends inverted byte
// - rx strips escape, inverts following byte
// - sleep asserts flow; wake releases or resumes
// - virtual queue uses dma threshold, timeout
// - trigger select 11 uses programmable trigger
// - access bit gates the divisor at offsets zero and four
module ueb_core (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic dcd_i,
    input wire logic dsr_i,
    input wire logic cts_i,
    input wire logic ring_indicator_input_n_i,
    input wire logic rx_i,
    input wire logic twentysix_mhz_tick_i,
    input wire logic sleep_i,
    input wire logic [1:0] rx_trig_sel_i,
    input wire logic [3:0] rx_level_i,
    input wire logic [3:0] dma_level_i,
    input wire logic [3:0] dma_threshold_i,
    input wire logic rx_idle_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_byte_valid_i,
    output logic tx_byte_ready_o,
    output logic [7:0] tx_out_byte_o,
    output logic tx_out_valid_o,
    output logic [7:0] rx_out_byte_o,
    output logic rx_out_valid_o,
    output logic baud_tick_o,
    output logic sample_o,
    output logic sample_valid_o,
    output logic rts_n_o,
    output logic send_resume_o,
    output logic send_pause_o,
    output logic xfer_gate_o,
    output logic guard_busy_o,
    output logic dma_timeout_o
);
    logic [7:0] lcr_q, div_lo_q, div_hi_q, efr_q, scr_q;
    logic [7:0] resume_char_one_q, resume_char_two_q, pause_char_one_q, pause_char_two_q;
    logic [7:0] scnt_q, spnt_q, escv_q;
    logic [1:0] speed_q;
    logic [3:0] rfix_q, rxtrig_q;
    logic [4:0] guard_q;
    logic [6:0] abdur_q;
    logic aben_q, escen_q, sleepen_q, vfifo_q;
    logic [7:0] abres_q;
    logic [3:0] dflag_q; // dcd, ring, dsr, cts
    logic [2:0] mlast_q;
    logic ring_last_q;
    logic enh, divisor_access_bit, msr_rd;
    logic [15:0] divisor;
    logic [15:0] div_cnt_q;
    logic [7:0] samp_cnt_q, base;
    logic [2:0] t13_cnt_q;
    logic tick13_q, gate_tick;
    logic [3:0] thresh, level;
    logic above;
    logic asleep_q;
    logic [3:0] stop_guard_length_q;
    logic esc_pend_q, rx_esc_q, rx_paused_q;
    logic [7:0] esc_byte_q;
    logic [15:0] idle_cnt_q;
    ueb_pkg::ueb_ab_t ab_q;

    assign enh = (lcr_q == ueb_pkg::ENH_KEY);
    assign divisor_access_bit = lcr_q[ueb_pkg::LCR_DIVISOR_ACCESS_BIT];
    assign divisor = {div_hi_q, div_lo_q};
    assign msr_rd = rd_i && !enh && addr_i == ueb_pkg::OFF_MSR;

    // register writes
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lcr_q <= 8'h00;
            div_lo_q <= ueb_pkg::RST_DIV[7:0];
            div_hi_q <= ueb_pkg::RST_DIV[15:8];
            efr_q <= 8'h00;
            scr_q <= 8'h00;
            resume_char_one_q <= 8'h00;
            resume_char_two_q <= 8'h00;
            pause_char_one_q <= 8'h00;
            pause_char_two_q <= 8'h00;
            aben_q <= 1'b0;
            speed_q <= 2'h0;
            scnt_q <= 8'h00;
            spnt_q <= ueb_pkg::RST_SPNT;
            rfix_q <= 4'h0;
            abdur_q <= ueb_pkg::RST_ABDUR;
            guard_q <= 5'h00;
            escv_q <= ueb_pkg::RST_ESCV;
            escen_q <= 1'b0;
            sleepen_q <= 1'b0;
            vfifo_q <= 1'b0;
            rxtrig_q <= 4'h0;
        end else if (wr_i) begin
            case (addr_i)
                ueb_pkg::OFF_LCR: lcr_q <= wdata_i[7:0];
                ueb_pkg::OFF_DIV_LO: if (divisor_access_bit) begin
                    div_lo_q <= wdata_i[7:0];
                end
                ueb_pkg::OFF_DIV_HI: if (divisor_access_bit) begin
                    div_hi_q <= wdata_i[7:0];
                end
                ueb_pkg::OFF_EFR: if (enh) efr_q <= wdata_i[7:0];
                ueb_pkg::OFF_RESUME_CHAR_ONE: if (enh) resume_char_one_q <= wdata_i[7:0];
                ueb_pkg::OFF_RESUME_CHAR_TWO: if (enh) resume_char_two_q <= wdata_i[7:0];
                ueb_pkg::OFF_MSR: if (enh) pause_char_one_q <= wdata_i[7:0];
                ueb_pkg::OFF_SCR: begin
                    if (enh) begin
                        pause_char_two_q <= wdata_i[7:0];
                    end else if (!divisor_access_bit) begin
                        scr_q <= wdata_i[7:0];
                    end
                end
                ueb_pkg::OFF_ABEN: aben_q <= wdata_i[0];
                ueb_pkg::OFF_SPEED: speed_q <= wdata_i[1:0];
                ueb_pkg::OFF_SCNT: scnt_q <= wdata_i[7:0];
                ueb_pkg::OFF_SPNT: spnt_q <= wdata_i[7:0];
                ueb_pkg::OFF_RFIX: rfix_q <= wdata_i[3:0];
                ueb_pkg::OFF_ABDUR: abdur_q <= wdata_i[6:0];
                ueb_pkg::OFF_GUARD: guard_q <= wdata_i[4:0];
                ueb_pkg::OFF_ESCV: escv_q <= wdata_i[7:0];
                ueb_pkg::OFF_ESCEN: escen_q <= wdata_i[0];
                ueb_pkg::OFF_SLEEP: sleepen_q <= wdata_i[0];
                ueb_pkg::OFF_VFIFO: vfifo_q <= wdata_i[0];
                ueb_pkg::OFF_RXTRIG: rxtrig_q <= wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                ueb_pkg::OFF_LCR: rdata_o <= {8'h00, lcr_q};
                ueb_pkg::OFF_DIV_LO: rdata_o <= {8'h00, divisor_access_bit ? div_lo_q : 8'h00};
                ueb_pkg::OFF_DIV_HI: rdata_o <= {8'h00, divisor_access_bit ? div_hi_q : 8'h00};
                ueb_pkg::OFF_EFR: rdata_o <= {8'h00, enh ? efr_q : 8'h00};
                ueb_pkg::OFF_RESUME_CHAR_ONE: rdata_o <= {8'h00, enh ? resume_char_one_q : 8'h00};
                ueb_pkg::OFF_RESUME_CHAR_TWO: rdata_o <= {8'h00, enh ? resume_char_two_q : 8'h00};
                ueb_pkg::OFF_MSR: rdata_o <= enh ? {8'h00, pause_char_one_q} :
                    {8'h00, dcd_i, !ring_indicator_input_n_i, dsr_i, cts_i,
                     dflag_q};
                ueb_pkg::OFF_SCR: rdata_o <= {8'h00, enh ? pause_char_two_q : scr_q};
                ueb_pkg::OFF_ABEN: rdata_o <= {15'h0000, aben_q};
                ueb_pkg::OFF_SPEED: rdata_o <= {14'h0000, speed_q};
                ueb_pkg::OFF_SCNT: rdata_o <= {8'h00, scnt_q};
                ueb_pkg::OFF_SPNT: rdata_o <= {8'h00, spnt_q};
                ueb_pkg::OFF_ABRES: rdata_o <= {8'h00, abres_q};
                ueb_pkg::OFF_RFIX: rdata_o <= {12'h000, rfix_q};
                ueb_pkg::OFF_ABDUR: rdata_o <= {9'h000, abdur_q};
                ueb_pkg::OFF_GUARD: rdata_o <= {11'h000, guard_q};
                ueb_pkg::OFF_ESCV: rdata_o <= {8'h00, escv_q};
                ueb_pkg::OFF_ESCEN: rdata_o <= {15'h0000, escen_q};
                ueb_pkg::OFF_SLEEP: rdata_o <= {15'h0000, sleepen_q};
                ueb_pkg::OFF_VFIFO: rdata_o <= {15'h0000, vfifo_q};
                ueb_pkg::OFF_RXTRIG: rdata_o <= {12'h000, rxtrig_q};
                ueb_pkg::OFF_FLOWST: rdata_o <= {12'h000, asleep_q, above,
                    rts_n_o, guard_busy_o};
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // modem delta flags, set wins over read clear
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dflag_q <= 4'h0;
            mlast_q <= 3'h0;
            ring_last_q <= 1'b0;
        end else begin
            mlast_q <= {dcd_i, dsr_i, cts_i};
            ring_last_q <= !ring_indicator_input_n_i;
            dflag_q[3] <= (dcd_i != mlast_q[2]) | (dflag_q[3] & !msr_rd);
            dflag_q[1] <= (dsr_i != mlast_q[1]) | (dflag_q[1] & !msr_rd);
            dflag_q[0] <= (cts_i != mlast_q[0]) | (dflag_q[0] & !msr_rd);
            // pin low last cycle, high now: trailing edge of the ring
            dflag_q[2] <= (ring_indicator_input_n_i & ring_last_q)
                | (dflag_q[2] & !msr_rd);
        end
    end

    // 13 MHz tick from every second 26 MHz tick
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            t13_cnt_q <= 3'h0;
            tick13_q <= 1'b0;
        end else begin
            tick13_q <= 1'b0;
            if (twentysix_mhz_tick_i) begin
                t13_cnt_q <= t13_cnt_q + 3'h1;
                tick13_q <= t13_cnt_q[0];
            end
        end
    end
    assign gate_tick = rfix_q[ueb_pkg::RF_FSEL] ? tick13_q
        : twentysix_mhz_tick_i;

    // oversampling base
    always_comb begin
        case (speed_q)
            2'd0: base = ueb_pkg::BASE_16;
            2'd1: base = ueb_pkg::BASE_8;
            2'd2: base = ueb_pkg::BASE_4;
            default: base = scnt_q;
        endcase
    end

    // divisor tick and sample counter
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_q <= 16'h0000;
            samp_cnt_q <= 8'h00;
            baud_tick_o <= 1'b0;
            sample_o <= 1'b1;
            sample_valid_o <= 1'b0;
            xfer_gate_o <= 1'b0;
        end else begin
            xfer_gate_o <= !rfix_q[ueb_pkg::RF_FIX] || gate_tick;
            sample_valid_o <= 1'b0;
            if (speed_q == 2'd3) begin
                baud_tick_o <= 1'b1;
                samp_cnt_q <= (samp_cnt_q >= scnt_q) ? 8'h00
                    : samp_cnt_q + 8'h01;
                if (samp_cnt_q == spnt_q) begin
                    sample_o <= rx_i;
                    sample_valid_o <= 1'b1;
                end
            end else begin
                if (divisor <= 16'h0001 || div_cnt_q >= divisor - 16'h0001) begin
                    div_cnt_q <= 16'h0000;
                    baud_tick_o <= 1'b1; // constant when one
                    samp_cnt_q <= (samp_cnt_q >= base) ? 8'h00
                        : samp_cnt_q + 8'h01;
                    if (samp_cnt_q == (base >> 1)) begin
                        sample_o <= rx_i;
                        sample_valid_o <= 1'b1;
                    end
                end else begin
                    div_cnt_q <= div_cnt_q + 16'h0001;
                    baud_tick_o <= 1'b0;
                end
            end
        end
    end

    // threshold and flow level
    assign thresh = (rx_trig_sel_i == ueb_pkg::TRIG_PROG) ? rxtrig_q
        : 4'h8;
    assign level = vfifo_q ? dma_level_i : rx_level_i;
    assign above = vfifo_q ? (dma_level_i >= dma_threshold_i)
        : (level >= thresh);

    // request line, pause/resume characters, sleep
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rts_n_o <= 1'b1;
            send_pause_o <= 1'b0;
            send_resume_o <= 1'b0;
            asleep_q <= 1'b0;
        end else begin
            asleep_q <= sleep_i && sleepen_q;
            rts_n_o <= efr_q[ueb_pkg::EFR_ARTS] &&
                (above || (sleep_i && sleepen_q));
            send_pause_o <= (efr_q[7:6] == 2'b00) && (efr_q[3:2] != 2'b00)
                && sleep_i && sleepen_q && !asleep_q;
            send_resume_o <= (efr_q[3:2] != 2'b00) && sleepen_q && asleep_q
                && !sleep_i && !above;
        end
    end

    // flow and escape character match
    function automatic logic is_special(input logic [7:0] b);
        logic hit;
        hit = (b == escv_q);
        if (efr_q[3]) hit = hit | (b == resume_char_one_q) | (b == pause_char_one_q);
        if (efr_q[2]) hit = hit | (b == resume_char_two_q) | (b == pause_char_two_q);
        return hit;
    endfunction

    // transmit path: escape insertion, clear-to-send, guard
    assign tx_byte_ready_o = !esc_pend_q && !tx_out_valid_o && !guard_busy_o
        && xfer_gate_o && !rx_paused_q
        && !(efr_q[ueb_pkg::EFR_ACTS] && !cts_i);
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            esc_pend_q <= 1'b0;
            esc_byte_q <= 8'h00;
            tx_out_byte_o <= 8'h00;
            tx_out_valid_o <= 1'b0;
            guard_busy_o <= 1'b0;
            stop_guard_length_q <= 4'h0;
        end else begin
            tx_out_valid_o <= 1'b0;
            if (tx_out_valid_o && guard_q[ueb_pkg::GD_EN]
                && guard_q[3:0] != 4'h0) begin
                guard_busy_o <= 1'b1;
                stop_guard_length_q <= guard_q[3:0];
            end else if (guard_busy_o && baud_tick_o) begin
                stop_guard_length_q <= stop_guard_length_q - 4'h1;
                if (stop_guard_length_q == 4'h1) guard_busy_o <= 1'b0;
            end
            if (esc_pend_q && !tx_out_valid_o) begin
                tx_out_byte_o <= ~esc_byte_q;
                tx_out_valid_o <= 1'b1;
                esc_pend_q <= 1'b0;
            end else if (tx_byte_valid_i && tx_byte_ready_o) begin
                tx_out_valid_o <= 1'b1;
                if (escen_q && is_special(tx_byte_i)) begin
                    tx_out_byte_o <= escv_q;
                    esc_byte_q <= tx_byte_i;
                    esc_pend_q <= 1'b1;
                end else begin
                    tx_out_byte_o <= tx_byte_i;
                end
            end
        end
    end

    // receive path: escape removal
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_esc_q <= 1'b0;
            rx_out_byte_o <= 8'h00;
            rx_out_valid_o <= 1'b0;
        end else begin
            rx_out_valid_o <= 1'b0;
            if (rx_byte_valid_i && xfer_gate_o) begin
                if (escen_q && !rx_esc_q && rx_byte_i == escv_q) begin
                    rx_esc_q <= 1'b1;
                end else begin
                    rx_esc_q <= 1'b0;
                    rx_out_byte_o <= rx_esc_q ? ~rx_byte_i : rx_byte_i;
                    rx_out_valid_o <= 1'b1;
                end
            end
        end
    end

    // received pause/resume characters stop or restart transmit
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_paused_q <= 1'b0;
        end else if (rx_byte_valid_i && xfer_gate_o && !rx_esc_q) begin
            if ((efr_q[1] && rx_byte_i == pause_char_one_q)
                || (efr_q[0] && rx_byte_i == pause_char_two_q)) begin
                rx_paused_q <= 1'b1;
            end else if ((efr_q[1] && rx_byte_i == resume_char_one_q)
                || (efr_q[0] && rx_byte_i == resume_char_two_q)) begin
                rx_paused_q <= 1'b0;
            end
        end
    end

    // dma idle timeout in virtual queue mode
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_cnt_q <= 16'h0000;
            dma_timeout_o <= 1'b0;
        end else begin
            dma_timeout_o <= 1'b0;
            if (!vfifo_q || rx_byte_valid_i || dma_level_i == 4'h0) begin
                idle_cnt_q <= 16'h0000;
            end else if (idle_cnt_q == {divisor[11:0], 4'h0}) begin
                dma_timeout_o <= 1'b1;
                idle_cnt_q <= 16'h0000;
            end else begin
                idle_cnt_q <= idle_cnt_q + 16'h0001;
            end
        end
    end

    // autobaud: start bit detection, result latch
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ab_q <= ueb_pkg::UEB_AB_IDLE;
            abres_q <= 8'h00;
        end else if (!aben_q) begin
            ab_q <= ueb_pkg::UEB_AB_IDLE;
        end else if (!rfix_q[ueb_pkg::RF_ABFIX] || gate_tick) begin
            case (ab_q)
                ueb_pkg::UEB_AB_IDLE: if (!rfix_q[ueb_pkg::RF_RESTR] || rx_idle_i)
                    ab_q <= ueb_pkg::UEB_AB_ARM;
                ueb_pkg::UEB_AB_ARM: if (!rx_i) ab_q <= ueb_pkg::UEB_AB_RUN;
                ueb_pkg::UEB_AB_RUN: if (rx_i) begin
                    abres_q <= 8'h00;
                    ab_q <= ueb_pkg::UEB_AB_IDLE;
                end
                default: ab_q <= ueb_pkg::UEB_AB_IDLE;
            endcase
        end
    end

    a_msr_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
        msr_rd && mlast_q[0] == cts_i ##1 cts_i == $past(cts_i)
        |-> !dflag_q[0]) else $error("cts flag not cleared");
    a_ring_edge: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(dflag_q[2]) |-> $past(ring_indicator_input_n_i)
        && !$past(ring_indicator_input_n_i, 2))
        else $error("ring flag without high input");
    a_div_lock: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_i && addr_i == ueb_pkg::OFF_DIV_LO && !divisor_access_bit |=> $stable(div_lo_q))
        else $error("divisor written while locked");
    a_enh_lock: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_i && addr_i == ueb_pkg::OFF_EFR && !enh |=> $stable(efr_q))
        else $error("feature reg written outside key");
    a_cts_pause: assert property (@(posedge mclk_i) disable iff (rst_i)
        efr_q[ueb_pkg::EFR_ACTS] && !cts_i |-> !tx_byte_ready_o)
        else $error("tx accepted while paused");
    a_samp_point: assert property (@(posedge mclk_i) disable iff (rst_i)
        speed_q == 2'd3 && samp_cnt_q == spnt_q |=> sample_valid_o)
        else $error("sample point missed");
    a_esc_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
        tx_out_valid_o && esc_pend_q |=> !tx_out_valid_o
        ##1 (tx_out_valid_o && tx_out_byte_o == ~esc_byte_q))
        else $error("escaped byte not inverted");
    a_rts_sleep: assert property (@(posedge mclk_i) disable iff (rst_i)
        efr_q[ueb_pkg::EFR_ARTS] && sleepen_q && sleep_i |=> rts_n_o)
        else $error("flow not asserted in sleep");
endmodule : ueb_core

// ---- tb/ueb_remote.sv ----
`timescale 1ns/1ps
// remote modem: handshake lines, idle serial line, 26 mhz enable
module ueb_remote (
    output logic dcd_o,
    output logic dsr_o,
    output logic cts_o,
    output logic ring_n_o,
    output logic rx_o,
    output logic tick26_o,
    input wire logic mclk_i
);
    logic [2:0] div_q = 3'h0;
    // quiet lines, serial input idles at mark
    initial begin
        {dcd_o, dsr_o, cts_o, ring_n_o} = 4'b0001;
        rx_o = 1'b1;
        tick26_o = 1'b0;
    end
    // handshake lines change just after an edge
    task automatic set_lines(input logic [3:0] ln);
        @(posedge mclk_i);
        {dcd_o, dsr_o, cts_o, ring_n_o} <= ln;
    endtask : set_lines
    // enable pulse on every fifth system clock
    always @(posedge mclk_i) begin
        div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
        tick26_o <= (div_q == 3'h4);
    end
endmodule : ueb_remote

// ---- tb/ueb_core_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin \
    cmp_count++; \
    if ((a) !== (b)) begin \
        mismatches++; \
        $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
    end \
end
module ueb_core_bench;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, txv = 0, rxv = 0;
    logic [7:0] addr = 0, txb = 0, rxb = 0, txo, rxo;
    logic [15:0] wdata = 0, rdata, txlog = 0, rxlog = 0;
    logic [3:0] rxlvl = 0;
    logic txrdy, txov, rxov, btick, smp, smpv, rtsn, dcd, dsr, cts, rin, rxs;
    logic t26, slp = 0;
    logic [1:0] trig = 0;
    int mismatches = 0, cmp_count = 0;
    ueb_remote P (.mclk_i(mclk), .dcd_o(dcd), .dsr_o(dsr), .cts_o(cts),
        .ring_n_o(rin), .rx_o(rxs), .tick26_o(t26));
    ueb_core DUT (.mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .dcd_i(dcd), .dsr_i(dsr),
        .cts_i(cts), .ring_indicator_input_n_i(rin), .rx_i(rxs),
        .twentysix_mhz_tick_i(t26), .sleep_i(slp), .rx_trig_sel_i(trig),
        .rx_level_i(rxlvl), .dma_level_i(4'h0), .dma_threshold_i(4'h0),
        .rx_idle_i(1'b1), .tx_byte_i(txb), .tx_byte_valid_i(txv),
        .rx_byte_i(rxb), .rx_byte_valid_i(rxv), .tx_byte_ready_o(txrdy),
        .tx_out_byte_o(txo), .tx_out_valid_o(txov), .rx_out_byte_o(rxo),
        .rx_out_valid_o(rxov), .baud_tick_o(btick), .sample_o(smp),
        .sample_valid_o(smpv), .rts_n_o(rtsn), .send_resume_o(),
        .send_pause_o(), .xfer_gate_o(), .guard_busy_o(),
        .dma_timeout_o());
    always #4 mclk = ~mclk;
    // log of bytes leaving both paths
    always @(posedge mclk) begin
        if (txov === 1'b1) txlog <= {txlog[7:0], txo};
        if (rxov === 1'b1) rxlog <= {rxlog[7:0], rxo};
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : chk_reg
    task automatic count_pulses(input bit sel, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge mclk);
            #1 c += sel ? smpv : btick;
        end
    endtask : count_pulses
    // line levels {dcd, dsr, cts, ring_n}; upper nibble shows the levels
    task automatic msr_step(input logic [3:0] ln, input logic [3:0] e);
        P.set_lines(ln);
        repeat (6) @(posedge mclk);
        chk_reg(8'h18, {8'h00, ln[3], !ln[0], ln[2:1], e});
    endtask : msr_step
    task automatic t_modem;
        msr_step(4'b0001, 4'h0);
        msr_step(4'b0111, 4'h3);
        msr_step(4'b0111, 4'h0);
        msr_step(4'b0110, 4'h0);
        msr_step(4'b1111, 4'hc);
    endtask : t_modem
    task automatic t_regs;
        chk_reg(8'h2c, 16'h00ff);
        chk_reg(8'h40, 16'h00ff);
        chk_reg(8'h38, 16'h000d);
        wr_reg(8'h38, 16'h0006);
        chk_reg(8'h38, 16'h0006);
        wr_reg(8'h30, 16'h00ff);
        chk_reg(8'h30, 16'h0000);
        chk_reg(8'h5c, 16'h0000);
        wr_reg(8'h1c, 16'h00a5);
        chk_reg(8'h1c, 16'h00a5);
        wr_reg(8'h0c, 16'h00bf);
        wr_reg(8'h1c, 16'h003c);
        wr_reg(8'h10, 16'h0031);
        wr_reg(8'h08, 16'h005a);
        chk_reg(8'h1c, 16'h003c);
        wr_reg(8'h0c, 16'h0000);
        chk_reg(8'h1c, 16'h00a5);
        wr_reg(8'h04, 16'h00aa);
        wr_reg(8'h0c, 16'h0080);
        chk_reg(8'h00, 16'h0001);
        chk_reg(8'h04, 16'h0000);
    endtask : t_regs
    task automatic t_rate;
        int c;
        int e[4] = '{6, 12, 24, 8};
        count_pulses(0, 32, c);
        `CHK(c, 32)
        wr_reg(8'h00, 16'h0003);
        repeat (20) @(posedge mclk);
        count_pulses(0, 30, c);
        `CHK(c, 10)
        wr_reg(8'h00, 16'h0000);
        wr_reg(8'h04, 16'h0001);
        repeat (300) @(posedge mclk);
        count_pulses(0, 512, c);
        `CHK(c, 2)
        wr_reg(8'h00, 16'h0001);
        wr_reg(8'h04, 16'h0000);
        wr_reg(8'h28, 16'h000b);
        wr_reg(8'h2c, 16'h0005);
        for (int s = 0; s < 4; s++) begin
            wr_reg(8'h24, 16'(s));
            repeat (40) @(posedge mclk);
            count_pulses(1, 96, c);
            `CHK(c, e[s])
        end
        wr_reg(8'h0c, 16'h0000);
    endtask : t_rate
    task automatic tx_send(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge mclk);
        txv <= 1'b1;
        txb <= b;
        @(negedge mclk);
        while (txrdy !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        txv <= 1'b0;
        repeat (40) @(posedge mclk);
    endtask : tx_send
    task automatic rx_send(input logic [7:0] b);
        @(posedge mclk);
        rxv <= 1'b1;
        rxb <= b;
        @(posedge mclk);
        rxv <= 1'b0;
    endtask : rx_send
    task automatic t_escape;
        wr_reg(8'h44, 16'h0001);
        txlog = 0;
        tx_send(8'h31);
        `CHK(txlog, 16'hffce)
        txlog = 0;
        tx_send(8'hff);
        `CHK(txlog, 16'hff00)
        rxlog = 0;
        rx_send(8'hff);
        rx_send(8'hce);
        rx_send(8'h55);
        repeat (10) @(posedge mclk);
        `CHK(rxlog, 16'h3155)
        wr_reg(8'h44, 16'h0000);
        txlog = 0;
        tx_send(8'h31);
        `CHK(txlog, 16'h0031)
        rxlog = 0;
        rx_send(8'hff);
        rx_send(8'hce);
        repeat (10) @(posedge mclk);
        `CHK(rxlog, 16'hffce)
        // received pause character holds transmit until resume
        rx_send(8'h00);
        txlog = 0;
        tx_send(8'h55);
        `CHK(txlog, 16'h0000)
        rx_send(8'h31);
        tx_send(8'h56);
        `CHK(txlog, 16'h0056)
    endtask : t_escape
    task automatic t_flow;
        @(posedge mclk);
        rxlvl <= 4'hf;
        repeat (8) @(posedge mclk);
        `CHK(rtsn, 1'b1)
        rxlvl <= 4'h0;
        repeat (8) @(posedge mclk);
        `CHK(rtsn, 1'b0)
        wr_reg(8'h48, 16'h0001);
        slp <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK(rtsn, 1'b1)
        slp <= 1'b0;
        wr_reg(8'h50, 16'h0003);
        trig <= 2'b11;
        rxlvl <= 4'h4;
        repeat (4) @(posedge mclk);
        `CHK(rtsn, 1'b1)
    endtask : t_flow
    task automatic finish_test;
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    // watchdog against a hung handshake
    initial begin
        #200000;
        mismatches++;
        finish_test;
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_modem;
        t_regs;
        t_rate;
        t_escape;
        t_flow;
        finish_test;
    end
endmodule : ueb_core_bench
